// File: src/cw1_defs.vh
`ifndef CW1_DEFS_VH
`define CW1_DEFS_VH

// Configuration word layout
`define CW1_WORD_W 14
`define CW1_WORD_RESET 14'h3FFF
`define CW1_DEBUG_BIT 13
`define CW1_LVP_BIT 12
`define CW1_FSCM_BIT 11
`define CW1_SWITCH_BIT 10
`define CW1_BOR_HI 9
`define CW1_BOR_LO 8
`define CW1_CPD_BIT 7
`define CW1_CP_BIT 6
`define CW1_MASTER_CLEAR_INPUT_BIT 5
`define CW1_PWRT_BIT 4
`define CW1_WDT_BIT 3
`define CW1_OSC_HI 2
`define CW1_OSC_LO 0

// Brown-out policy codes
`define CW1_BOR_ALWAYS 2'h3
`define CW1_BOR_RUN 2'h2
`define CW1_BOR_SOFT 2'h1
`define CW1_BOR_OFF 2'h0

// Oscillator select codes
`define CW1_OSC_RC_CLKOUT 3'h7
`define CW1_OSC_RC_IO 3'h6
`define CW1_OSC_INT_CLKOUT 3'h5
`define CW1_OSC_INT_IO 3'h4
`define CW1_OSC_EXT_CLOCK 3'h3
`define CW1_OSC_HS 3'h2
`define CW1_OSC_XT 3'h1
`define CW1_OSC_RESET 3'h7

// Register map (byte addresses)
`define CW1_ADDR_WORD 12'h000
`define CW1_ADDR_CTRL 12'h004
`define CW1_ADDR_STAT 12'h008

// Control and status fields
`define CW1_CTRL_SWBOR 0
`define CW1_CTRL_RESET 1'h0
`define CW1_STAT_VALID 0
`define CW1_STAT_BOR 1
`define CW1_STAT_ERASED 2
`define CW1_STAT_MASTER_CLEAR_INPUT_PIN 3

// Load sequencing after reset release
`define CW1_LOAD_W 2
`define CW1_LOAD_CYCLES 2'h2
`define CW1_LOAD_ZERO 2'h0
`define CW1_LOAD_STEP 2'h1

`endif

// File: src/cw1_decoder.v
// The register addresses and the APB register port were left to the implementer.
`include "cw1_defs.vh"

module cw1_decoder #(
    parameter ADDR_W = 12
) (
    CLOCK,
    RESET_N,
    CONFIG_WORD,
    SLEEP,
    MASTER_CLEAR_PIN,
    PSEL,
    PENABLE,
    PWRITE,
    PADDR,
    PWDATA,
    PRDATA,
    PREADY,
    PSLVERR,
    CONFIG_VALID,
    DEBUG_PINS_DEDICATED,
    LV_ENTRY_PIN_FUNCTION,
    HV_PROGRAM_REQUIRED,
    FAILSAFE_MONITOR_ENABLE,
    SWITCHOVER_ENABLE,
    BROWNOUT_RESET_ENABLE,
    DATA_MEMORY_PROTECT,
    PROGRAM_MEMORY_PROTECT,
    DATA_EEPROM_ERASE,
    RESET_PIN_IS_MASTER_CLEAR,
    INTERNAL_MASTER_CLEAR_N,
    RESET_PIN_DIGITAL_IN,
    POWERUP_DELAY_ENABLE,
    WATCHDOG_CONFIG_ENABLE,
    OSC_SELECT,
    OSC_CLOCK_OUT_ENABLE,
    OSC_EXTERNAL_RC,
    OSC_INTERNAL,
    OSC_EXTERNAL_CLOCK,
    OSC_HIGH_SPEED_CRYSTAL,
    OSC_STANDARD_CRYSTAL
);
    input wire CLOCK;
    input wire RESET_N;
    input wire [`CW1_WORD_W-1:0] CONFIG_WORD;
    input wire SLEEP;
    input wire MASTER_CLEAR_PIN;
    input wire PSEL;
    input wire PENABLE;
    input wire PWRITE;
    input wire [ADDR_W-1:0] PADDR;
    input wire [31:0] PWDATA;
    output wire [31:0] PRDATA;
    output wire PREADY;
    output wire PSLVERR;
    output wire CONFIG_VALID;
    output wire DEBUG_PINS_DEDICATED;
    output wire LV_ENTRY_PIN_FUNCTION;
    output wire HV_PROGRAM_REQUIRED;
    output wire FAILSAFE_MONITOR_ENABLE;
    output wire SWITCHOVER_ENABLE;
    output wire BROWNOUT_RESET_ENABLE;
    output wire DATA_MEMORY_PROTECT;
    output wire PROGRAM_MEMORY_PROTECT;
    output wire DATA_EEPROM_ERASE;
    output wire RESET_PIN_IS_MASTER_CLEAR;
    output wire INTERNAL_MASTER_CLEAR_N;
    output wire RESET_PIN_DIGITAL_IN;
    output wire POWERUP_DELAY_ENABLE;
    output wire WATCHDOG_CONFIG_ENABLE;
    output wire [2:0] OSC_SELECT;
    output wire OSC_CLOCK_OUT_ENABLE;
    output wire OSC_EXTERNAL_RC;
    output wire OSC_INTERNAL;
    output wire OSC_EXTERNAL_CLOCK;
    output wire OSC_HIGH_SPEED_CRYSTAL;
    output wire OSC_STANDARD_CRYSTAL;

    ////////////////////////////////////////////////////////////////////////////////
    // Brown-out policy decode
    function cw1_bor_active;
        input [1:0] policy;
        input sleeping;
        input soft_enable;
        begin
            case (policy)
                `CW1_BOR_ALWAYS: cw1_bor_active = 1'b1;
                `CW1_BOR_RUN: cw1_bor_active = ~sleeping;
                `CW1_BOR_SOFT: cw1_bor_active = soft_enable;
                default: cw1_bor_active = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg [`CW1_WORD_W-1:0] word_meta_reg;
    reg [`CW1_WORD_W-1:0] word_sync_reg;
    reg cpd_last_reg;
    reg master_clear_input_meta_reg;
    reg master_clear_input_sync_reg;

    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            word_meta_reg <= `CW1_WORD_RESET;
            word_sync_reg <= `CW1_WORD_RESET;
            cpd_last_reg <= 1'b1;
            master_clear_input_meta_reg <= 1'b1;
            master_clear_input_sync_reg <= 1'b1;
        end else begin
            word_meta_reg <= CONFIG_WORD;
            word_sync_reg <= word_meta_reg;
            cpd_last_reg <= word_sync_reg[`CW1_CPD_BIT];
            master_clear_input_meta_reg <= MASTER_CLEAR_PIN;
            master_clear_input_sync_reg <= master_clear_input_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture of the word once after reset release
    reg [`CW1_LOAD_W-1:0] load_count_reg;
    reg valid_reg;
    reg [`CW1_WORD_W-1:0] held_reg;
    wire load_now;

    assign load_now = ~valid_reg && (load_count_reg == `CW1_LOAD_CYCLES);

    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            load_count_reg <= `CW1_LOAD_ZERO;
            valid_reg <= 1'b0;
            held_reg <= `CW1_WORD_RESET;
        end else if (load_now) begin
            valid_reg <= 1'b1;
            held_reg <= word_sync_reg;
        end else if (~valid_reg) begin
            load_count_reg <= load_count_reg + `CW1_LOAD_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave
    reg [31:0] prdata_reg;
    reg pready_reg;
    reg pslverr_reg;
    reg soft_bor_reg;
    reg erased_reg;
    reg bor_reg;
    reg [31:0] rdata;
    reg addr_ok;
    reg write_ok;
    wire setup_phase;
    wire access_done;

    assign setup_phase = PSEL && ~PENABLE && ~pready_reg;
    assign access_done = PSEL && PENABLE && pready_reg;

    always @* begin
        rdata = 32'h0000_0000;
        addr_ok = 1'b1;
        write_ok = 1'b0;
        case (PADDR)
            `CW1_ADDR_WORD: begin
                rdata[`CW1_WORD_W-1:0] = held_reg;
            end
            `CW1_ADDR_CTRL: begin
                rdata[`CW1_CTRL_SWBOR] = soft_bor_reg;
                write_ok = 1'b1;
            end
            `CW1_ADDR_STAT: begin
                rdata[`CW1_STAT_VALID] = valid_reg;
                rdata[`CW1_STAT_BOR] = bor_reg;
                rdata[`CW1_STAT_ERASED] = erased_reg;
                rdata[`CW1_STAT_MASTER_CLEAR_INPUT_PIN] = master_clear_input_sync_reg;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            soft_bor_reg <= `CW1_CTRL_RESET;
        end else begin
            if (setup_phase) begin
                pready_reg <= 1'b1;
                prdata_reg <= PWRITE ? 32'h0000_0000 : rdata;
                pslverr_reg <= ~addr_ok | (PWRITE & ~write_ok);
            end else begin
                pready_reg <= 1'b0;
                pslverr_reg <= 1'b0;
            end
            if (access_done && PWRITE && write_ok) begin
                soft_bor_reg <= PWDATA[`CW1_CTRL_SWBOR];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded settings
    reg debug_reg;
    reg lv_entry_reg;
    reg hv_req_reg;
    reg fscm_reg;
    reg switch_reg;
    reg dprot_reg;
    reg pprot_reg;
    reg erase_reg;
    reg master_clear_input_fn_reg;
    reg int_master_clear_input_n_reg;
    reg pin_in_reg;
    reg pwrt_reg;
    reg wdt_reg;
    reg [2:0] osc_reg;
    reg clkout_reg;
    reg rc_reg;
    reg int_osc_reg;
    reg ext_clk_reg;
    reg hs_reg;
    reg xt_reg;
    wire [2:0] osc_field;
    wire cpd_turned_off;

    assign osc_field = held_reg[`CW1_OSC_HI:`CW1_OSC_LO];
    assign cpd_turned_off = valid_reg && ~held_reg[`CW1_CPD_BIT] &&
        word_sync_reg[`CW1_CPD_BIT] && ~cpd_last_reg;

    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            debug_reg <= 1'b0;
            lv_entry_reg <= 1'b0;
            hv_req_reg <= 1'b1;
            fscm_reg <= 1'b0;
            switch_reg <= 1'b0;
            bor_reg <= 1'b0;
            dprot_reg <= 1'b1;
            pprot_reg <= 1'b1;
            erase_reg <= 1'b0;
            erased_reg <= 1'b0;
            master_clear_input_fn_reg <= 1'b1;
            int_master_clear_input_n_reg <= 1'b1;
            pin_in_reg <= 1'b0;
            pwrt_reg <= 1'b0;
            wdt_reg <= 1'b0;
            osc_reg <= `CW1_OSC_RESET;
            clkout_reg <= 1'b0;
            rc_reg <= 1'b0;
            int_osc_reg <= 1'b0;
            ext_clk_reg <= 1'b0;
            hs_reg <= 1'b0;
            xt_reg <= 1'b0;
        end else begin
            debug_reg <= valid_reg & ~held_reg[`CW1_DEBUG_BIT];
            lv_entry_reg <= valid_reg & held_reg[`CW1_LVP_BIT];
            hv_req_reg <= ~(valid_reg & held_reg[`CW1_LVP_BIT]);
            fscm_reg <= valid_reg & held_reg[`CW1_FSCM_BIT];
            switch_reg <= valid_reg & held_reg[`CW1_SWITCH_BIT];
            bor_reg <= valid_reg &
                cw1_bor_active(held_reg[`CW1_BOR_HI:`CW1_BOR_LO], SLEEP, soft_bor_reg);
            dprot_reg <= ~valid_reg | ~held_reg[`CW1_CPD_BIT];
            pprot_reg <= ~valid_reg | ~held_reg[`CW1_CP_BIT];
            erase_reg <= cpd_turned_off;
            if (cpd_turned_off) begin
                erased_reg <= 1'b1;
            end
            master_clear_input_fn_reg <= ~valid_reg | held_reg[`CW1_MASTER_CLEAR_INPUT_BIT];
            if (valid_reg && held_reg[`CW1_MASTER_CLEAR_INPUT_BIT]) begin
                int_master_clear_input_n_reg <= master_clear_input_sync_reg;
                pin_in_reg <= 1'b0;
            end else begin
                int_master_clear_input_n_reg <= 1'b1;
                pin_in_reg <= valid_reg & master_clear_input_sync_reg;
            end
            pwrt_reg <= valid_reg & ~held_reg[`CW1_PWRT_BIT];
            wdt_reg <= valid_reg & held_reg[`CW1_WDT_BIT];
            osc_reg <= osc_field;
            clkout_reg <= valid_reg && ((osc_field == `CW1_OSC_RC_CLKOUT) ||
                (osc_field == `CW1_OSC_INT_CLKOUT));
            rc_reg <= valid_reg && ((osc_field == `CW1_OSC_RC_CLKOUT) ||
                (osc_field == `CW1_OSC_RC_IO));
            int_osc_reg <= valid_reg && ((osc_field == `CW1_OSC_INT_CLKOUT) ||
                (osc_field == `CW1_OSC_INT_IO));
            ext_clk_reg <= valid_reg && (osc_field == `CW1_OSC_EXT_CLOCK);
            hs_reg <= valid_reg && (osc_field == `CW1_OSC_HS);
            xt_reg <= valid_reg && (osc_field == `CW1_OSC_XT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign CONFIG_VALID = valid_reg;
    assign DEBUG_PINS_DEDICATED = debug_reg;
    assign LV_ENTRY_PIN_FUNCTION = lv_entry_reg;
    assign HV_PROGRAM_REQUIRED = hv_req_reg;
    assign FAILSAFE_MONITOR_ENABLE = fscm_reg;
    assign SWITCHOVER_ENABLE = switch_reg;
    assign BROWNOUT_RESET_ENABLE = bor_reg;
    assign DATA_MEMORY_PROTECT = dprot_reg;
    assign PROGRAM_MEMORY_PROTECT = pprot_reg;
    assign DATA_EEPROM_ERASE = erase_reg;
    assign RESET_PIN_IS_MASTER_CLEAR = master_clear_input_fn_reg;
    assign INTERNAL_MASTER_CLEAR_N = int_master_clear_input_n_reg;
    assign RESET_PIN_DIGITAL_IN = pin_in_reg;
    assign POWERUP_DELAY_ENABLE = pwrt_reg;
    assign WATCHDOG_CONFIG_ENABLE = wdt_reg;
    assign OSC_SELECT = osc_reg;
    assign OSC_CLOCK_OUT_ENABLE = clkout_reg;
    assign OSC_EXTERNAL_RC = rc_reg;
    assign OSC_INTERNAL = int_osc_reg;
    assign OSC_EXTERNAL_CLOCK = ext_clk_reg;
    assign OSC_HIGH_SPEED_CRYSTAL = hs_reg;
    assign OSC_STANDARD_CRYSTAL = xt_reg;

endmodule

// File: verif/cw1_decoder_chk.sv
`include "cw1_defs.vh"
module cw1_decoder_chk (
    input wire CLOCK,
    input wire RESET_N,
    input wire [`CW1_WORD_W-1:0] CONFIG_WORD,
    input wire SLEEP,
    input wire PSEL,
    input wire PENABLE,
    input wire PREADY,
    input wire CONFIG_VALID,
    input wire DEBUG_PINS_DEDICATED,
    input wire LV_ENTRY_PIN_FUNCTION,
    input wire HV_PROGRAM_REQUIRED,
    input wire FAILSAFE_MONITOR_ENABLE,
    input wire BROWNOUT_RESET_ENABLE,
    input wire DATA_MEMORY_PROTECT,
    input wire DATA_EEPROM_ERASE,
    input wire RESET_PIN_IS_MASTER_CLEAR,
    input wire INTERNAL_MASTER_CLEAR_N,
    input wire [2:0] OSC_SELECT,
    input wire OSC_CLOCK_OUT_ENABLE,
    input wire OSC_EXTERNAL_CLOCK
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);
    reg [1:0] vld_cnt_reg;
    wire ok = (vld_cnt_reg == 2'h3);
    // Counts settled cycles after the word is captured
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            vld_cnt_reg <= 2'h0;
        end else if (CONFIG_VALID && !ok) begin
            vld_cnt_reg <= vld_cnt_reg + 2'h1;
        end
    end
    AST_DEBUG: assert property (ok |-> DEBUG_PINS_DEDICATED == !CONFIG_WORD[13])
        else $error("debug pin ownership wrong");
    AST_LVP: assert property (ok |-> LV_ENTRY_PIN_FUNCTION == CONFIG_WORD[12]
        && HV_PROGRAM_REQUIRED == !CONFIG_WORD[12]) else $error("entry pin mode wrong");
    AST_FSCM: assert property (ok |-> FAILSAFE_MONITOR_ENABLE == CONFIG_WORD[11])
        else $error("clock monitor enable wrong");
    AST_BOR_ALWAYS: assert property (ok && CONFIG_WORD[9:8] == 2'h3 |-> BROWNOUT_RESET_ENABLE)
        else $error("brown-out not always on");
    AST_BOR_RUN: assert property (ok && CONFIG_WORD[9:8] == 2'h2
        |-> BROWNOUT_RESET_ENABLE == !$past(SLEEP)) else $error("brown-out sleep gating wrong");
    AST_ERASE: assert property (DATA_EEPROM_ERASE |-> DATA_MEMORY_PROTECT ##1 !DATA_EEPROM_ERASE)
        else $error("erase pulse wrong");
    AST_MASTER_CLEAR_INPUT: assert property (!RESET_PIN_IS_MASTER_CLEAR |-> INTERNAL_MASTER_CLEAR_N)
        else $error("master clear not tied inactive");
    AST_OSC: assert property (ok |-> OSC_SELECT == CONFIG_WORD[2:0]
        && OSC_EXTERNAL_CLOCK == (OSC_SELECT == 3'h3)
        && OSC_CLOCK_OUT_ENABLE == (OSC_SELECT[2] && OSC_SELECT[0])) else $error("osc decode wrong");
    AST_HOLD: assert property (ok && $past(ok) |-> $stable(OSC_SELECT)
        && $stable(DATA_MEMORY_PROTECT) && $stable(DEBUG_PINS_DEDICATED))
        else $error("decoded value changed");
    AST_APB_READY: assert property (PSEL && PENABLE |-> PREADY) else $error("no ready in access");
endmodule

bind cw1_decoder cw1_decoder_chk chk_u (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .CONFIG_WORD(CONFIG_WORD), .SLEEP(SLEEP),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .CONFIG_VALID(CONFIG_VALID),
    .DEBUG_PINS_DEDICATED(DEBUG_PINS_DEDICATED), .LV_ENTRY_PIN_FUNCTION(LV_ENTRY_PIN_FUNCTION),
    .HV_PROGRAM_REQUIRED(HV_PROGRAM_REQUIRED), .FAILSAFE_MONITOR_ENABLE(FAILSAFE_MONITOR_ENABLE),
    .BROWNOUT_RESET_ENABLE(BROWNOUT_RESET_ENABLE), .DATA_MEMORY_PROTECT(DATA_MEMORY_PROTECT),
    .DATA_EEPROM_ERASE(DATA_EEPROM_ERASE), .RESET_PIN_IS_MASTER_CLEAR(RESET_PIN_IS_MASTER_CLEAR),
    .INTERNAL_MASTER_CLEAR_N(INTERNAL_MASTER_CLEAR_N), .OSC_SELECT(OSC_SELECT),
    .OSC_CLOCK_OUT_ENABLE(OSC_CLOCK_OUT_ENABLE), .OSC_EXTERNAL_CLOCK(OSC_EXTERNAL_CLOCK)
);

// File: verif/cw1_programmer.sv
module cw1_programmer (
    output logic [13:0] config_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] word_reg = 14'h3FFF;
    assign config_word = word_reg;
    // Word stays put until the programmer writes again
    task automatic write_word(input logic [13:0] w);
        word_reg <= w;
    endtask
    // Clears data protection in the stored word
    task automatic lift_data_protect();
        word_reg[7] <= 1'b1;
    endtask
endmodule

// File: verif/cw1_decoder_tb_top.sv
module cw1_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic sleep = 1'b0;
    logic pin = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire [13:0] cfg;
    wire [2:0] osel;
    wire pready, pslverr, valid, dbg, lv, hv, fscm, bor, dmp, erase, mcm, imc_n, rdin;
    wire ock, orc, oint, oext, ohs, oxt, sw, pmp, pwr, wdg;
    int n_fail = 0;
    int samples_checked = 0;
    logic [5:0] osc_tab [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h28, 6'h10, 6'h30};
    always #5 clock = ~clock;
    cw1_programmer prog_u (.config_word(cfg));
    cw1_decoder dut_u (
        .CLOCK(clock), .RESET_N(reset_n), .CONFIG_WORD(cfg), .SLEEP(sleep),
        .MASTER_CLEAR_PIN(pin), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CONFIG_VALID(valid), .DEBUG_PINS_DEDICATED(dbg), .LV_ENTRY_PIN_FUNCTION(lv),
        .HV_PROGRAM_REQUIRED(hv), .FAILSAFE_MONITOR_ENABLE(fscm), .SWITCHOVER_ENABLE(sw),
        .BROWNOUT_RESET_ENABLE(bor), .DATA_MEMORY_PROTECT(dmp), .PROGRAM_MEMORY_PROTECT(pmp),
        .DATA_EEPROM_ERASE(erase), .RESET_PIN_IS_MASTER_CLEAR(mcm),
        .INTERNAL_MASTER_CLEAR_N(imc_n), .RESET_PIN_DIGITAL_IN(rdin),
        .POWERUP_DELAY_ENABLE(pwr), .WATCHDOG_CONFIG_ENABLE(wdg), .OSC_SELECT(osel),
        .OSC_CLOCK_OUT_ENABLE(ock), .OSC_EXTERNAL_RC(orc), .OSC_INTERNAL(oint),
        .OSC_EXTERNAL_CLOCK(oext), .OSC_HIGH_SPEED_CRYSTAL(ohs), .OSC_STANDARD_CRYSTAL(oxt)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk(32'(pready), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic boot(input logic [13:0] w);
        int n;
        n = 0;
        reset_n <= 1'b0;
        prog_u.write_word(w);
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        while (valid !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        repeat (3) @(posedge clock);
        chk(32'(valid), 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_fields();
        logic [13:0] w;
        logic [31:0] rd;
        logic err;
        for (int i = 0; i < 8; i++) begin
            w = {i[0], i[1], i[2], i[1], 2'h3, 1'b1, i[2], i[0] ^ i[1], i[0], i[2], 3'(i)};
            boot(w);
            chk(32'({sw, pmp, pwr, wdg}), 32'({w[10], !w[6], !w[4], w[3]}));
            chk(32'(dbg), 32'(!w[13]));
            chk(32'({lv, hv}), 32'({w[12], !w[12]}));
            chk(32'(fscm), 32'(w[11]));
            chk(32'(mcm), 32'(w[5]));
            chk(32'(osel), 32'(i));
            chk(32'({ock, orc, oint, oext, ohs, oxt}), 32'(osc_tab[i]));
            apb(1'b1, 12'h000, 32'h0, rd, err);
            chk(32'(err), 32'h1);
            apb(1'b0, 12'h000, 32'h0, rd, err);
            chk(rd, 32'(w));
        end
    endtask
    task automatic test_bor();
        logic [31:0] rd;
        logic err;
        boot(14'h3FFF);
        sleep <= 1'b1;
        repeat (2) @(posedge clock);
        chk(32'(bor), 32'h1);
        boot(14'h3EFF);
        chk(32'(bor), 32'h0);
        sleep <= 1'b0;
        repeat (2) @(posedge clock);
        chk(32'(bor), 32'h1);
        boot(14'h3DFF);
        apb(1'b0, 12'h004, 32'h0, rd, err);
        chk(rd, 32'h0);
        chk(32'(bor), 32'h0);
        apb(1'b1, 12'h004, 32'h1, rd, err);
        repeat (2) @(posedge clock);
        chk(32'(bor), 32'h1);
        apb(1'b0, 12'h008, 32'h0, rd, err);
        chk(32'(rd[1]), 32'h1);
        apb(1'b0, 12'h00C, 32'h0, rd, err);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
    endtask
    task automatic test_erase();
        logic [31:0] rd;
        logic err;
        int n;
        n = 0;
        boot(14'h3F7F);
        chk(32'({dmp, erase}), 32'h2);
        prog_u.lift_data_protect();
        while (erase !== 1'b1 && n < 12) begin
            @(posedge clock);
            n++;
        end
        chk(32'(erase), 32'h1);
        @(posedge clock);
        chk(32'({dmp, erase}), 32'h2);
        apb(1'b0, 12'h008, 32'h0, rd, err);
        chk(32'(rd[2]), 32'h1);
    endtask
    task automatic test_master_clear_input();
        boot(14'h3FFF);
        pin <= 1'b0;
        repeat (6) @(posedge clock);
        chk(32'({imc_n, rdin}), 32'h0);
        pin <= 1'b1;
        boot(14'h3FDF);
        pin <= 1'b0;
        repeat (6) @(posedge clock);
        chk(32'({imc_n, rdin}), 32'h2);
        pin <= 1'b1;
        repeat (6) @(posedge clock);
        chk(32'({imc_n, rdin}), 32'h3);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        test_fields();
        test_bor();
        test_erase();
        test_master_clear_input();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        complete_run();
    end
endmodule
